//--- hdl/vpiu_pkg.sv
// Shared constants for the vectored priority interrupt unit
package vpiu_pkg;
   // ****************************************
   // Vector space and level encoding
   // ****************************************
   localparam int NUM_VEC = 22;
   localparam int VEC_W = 5;
   localparam int LVL_W = 2;
   localparam int ADDR_W = 21;
   // Each vector occupies two program words, so offset is vector shifted by this
   localparam int VEC_SHIFT = 1;
   localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
   localparam logic [VEC_W-1:0] VEC_WATCHDOG_RESET = 5'h01;
   localparam logic [VEC_W-1:0] VEC_EXT_A = 5'h11;
   localparam logic [VEC_W-1:0] VEC_EXT_B = 5'h12;
   localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
   localparam logic [LVL_W-1:0] DEBUG_LVL_MIN = 2'h1;
   localparam logic [LVL_W-1:0] EXT_LVL_MAX = 2'h2;
   localparam logic [LVL_W-1:0] EXT_LVL_RST = 2'h0;

   // ****************************************
   // Per-vector kind and fixed level maps (vector 21 leftmost)
   // ****************************************
   localparam logic [LVL_W-1:0] KIND_NONE = 2'h0;
   localparam logic [LVL_W-1:0] KIND_FIXED = 2'h1;
   localparam logic [LVL_W-1:0] KIND_DEBUG = 2'h2;
   localparam logic [LVL_W-1:0] KIND_EXT = 2'h3;
   localparam logic [NUM_VEC*LVL_W-1:0] KIND_MAP = {
      2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2,
      2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
   localparam logic [NUM_VEC*LVL_W-1:0] FIXED_LVL_MAP = {
      2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0,
      2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0};
endpackage

//--- hdl/vpiu_level_table.sv
// Per-vector priority level table with fixed and programmable entries
`timescale 1ns/1ps
module vpiu_level_table
   import vpiu_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cfg_wr_i,
   input wire logic [VEC_W-1:0] cfg_vec_i,
   input wire logic [LVL_W-1:0] cfg_level_i,
   output logic [NUM_VEC*LVL_W-1:0] levels_o
);
   logic [NUM_VEC*LVL_W-1:0] lvl_d;
   logic [NUM_VEC*LVL_W-1:0] lvl_q;

   // ****************************************
   // One entry per vector
   // ****************************************
   for (genvar v = 0; v < NUM_VEC; v++) begin : g_ent
      localparam logic [LVL_W-1:0] KIND = KIND_MAP[v*LVL_W +: LVL_W];
      localparam logic [LVL_W-1:0] FIX = FIXED_LVL_MAP[v*LVL_W +: LVL_W];
      // Out-of-range writes are clamped, never stored as given
      always_comb begin
         lvl_d[v*LVL_W +: LVL_W] = lvl_q[v*LVL_W +: LVL_W];
         if (KIND == KIND_FIXED || KIND == KIND_NONE) begin
            lvl_d[v*LVL_W +: LVL_W] = FIX;
         end else if (cfg_wr_i && cfg_vec_i == VEC_W'(v)) begin
            if (KIND == KIND_DEBUG) begin
               // Debug sources cannot drop below level 1
               lvl_d[v*LVL_W +: LVL_W] = (cfg_level_i < DEBUG_LVL_MIN) ?
                  DEBUG_LVL_MIN : cfg_level_i;
            end else begin
               // Pins, detector and synthesizer top out at level 2
               lvl_d[v*LVL_W +: LVL_W] = (cfg_level_i > EXT_LVL_MAX) ?
                  EXT_LVL_MAX : cfg_level_i;
            end
         end
      end
      // Reset values: debug at its floor, others at fixed or zero
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            lvl_q[v*LVL_W +: LVL_W] <= (KIND == KIND_DEBUG) ? DEBUG_LVL_MIN :
               (KIND == KIND_EXT) ? EXT_LVL_RST : FIX;
         end else begin
            lvl_q[v*LVL_W +: LVL_W] <= lvl_d[v*LVL_W +: LVL_W];
         end
      end
   end

   assign levels_o = lvl_q;
endmodule

//--- hdl/vpiu_core.sv
// Vectored priority interrupt arbiter and vector address generator
//
// Summary of operation
// - Higher priority level always wins arbitration.
// - Same level: smallest vector number wins.
// - Vector addresses relative to writable table base.
// - Vector offset equals twice the vector number.
// - Core exceptions level 3; software interrupts 2,1,0.
// - Debug-unit vectors programmable at levels 1-3.
// - Pins, detector, synthesizer programmable levels 0-2.
// - Vectors 0,1 reserved for reset overlays.
`timescale 1ns/1ps
module vpiu_core
   import vpiu_pkg::*;
#(
   parameter int ADDR_WIDTH = ADDR_W
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [NUM_VEC-1:0] core_req_i,
   input wire logic external_request_a_i,
   input wire logic external_request_b_i,
   input wire logic [ADDR_WIDTH-1:0] vector_table_base_i,
   input wire logic vector_table_base_wr_i,
   input wire logic cfg_wr_i,
   input wire logic [VEC_W-1:0] cfg_vec_i,
   input wire logic [LVL_W-1:0] cfg_level_i,
   input wire logic [LVL_W-1:0] core_mask_level_i,
   input wire logic ack_i,
   output logic irq_o,
   output logic [VEC_W-1:0] vector_num_o,
   output logic [LVL_W-1:0] level_o,
   output logic [ADDR_WIDTH-1:0] vector_addr_o,
   output logic [ADDR_WIDTH-1:0] reset_addr_o,
   output logic [ADDR_WIDTH-1:0] watchdog_reset_addr_o,
   output logic [NUM_VEC-1:0] pending_o
);
   // ****************************************
   // Elaboration check
   // ****************************************
   if (ADDR_WIDTH < VEC_W + VEC_SHIFT) begin : g_bad_width
      $error("vpiu_core: ADDR_WIDTH too small for vector offsets");
   end
   // Every vector number must fit the vector field
   if (NUM_VEC > (1 << VEC_W)) begin : g_bad_count
      $error("vpiu_core: vector count exceeds vector field");
   end

   // ****************************************
   // Assigned vectors
   // ****************************************
   logic [NUM_VEC-1:0] assigned;
   for (genvar v = 0; v < NUM_VEC; v++) begin : g_asg
      // Reserved and unassigned slots carry kind none
      assign assigned[v] = (KIND_MAP[v*LVL_W +: LVL_W] != KIND_NONE);
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] pin_meta_d;
   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_d;
   logic [1:0] pin_sync_q;
   // First flop may go metastable; only the second is read
   always_comb begin
      pin_meta_d = {external_request_b_i, external_request_a_i};
      pin_sync_d = pin_meta_q;
   end
   // Pins clear to idle low so reset brings no false request
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end else begin
         pin_meta_q <= pin_meta_d;
         pin_sync_q <= pin_sync_d;
      end
   end

   // ****************************************
   // Level table
   // ****************************************
   logic [NUM_VEC*LVL_W-1:0] levels;
   // Programmable levels live in their own table module
   vpiu_level_table u_levels (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .cfg_wr_i(cfg_wr_i),
      .cfg_vec_i(cfg_vec_i),
      .cfg_level_i(cfg_level_i),
      .levels_o(levels)
   );

   // ****************************************
   // Arbitration function
   // ****************************************
   // Scan levels top down, vectors bottom up; first hit wins
   function automatic logic [VEC_W:0] pick(input logic [NUM_VEC-1:0] elig,
                                           input logic [NUM_VEC*LVL_W-1:0] lv);
      logic found;
      logic [VEC_W-1:0] win;
      found = 1'b0;
      win = '0;
      for (int l = 3; l >= 0; l--) begin
         for (int v = 0; v < NUM_VEC; v++) begin
            if (!found && elig[v] && lv[v*LVL_W +: LVL_W] == LVL_W'(l)) begin
               found = 1'b1;
               win = VEC_W'(v);
            end
         end
      end
      return {found, win};
   endfunction

   // ****************************************
   // Pending, arbitration and vector state
   // ****************************************
   logic [NUM_VEC-1:0] pend_d;
   logic [NUM_VEC-1:0] pend_q;
   logic [ADDR_WIDTH-1:0] base_d;
   logic [ADDR_WIDTH-1:0] base_q;
   logic irq_d;
   logic irq_q;
   logic [VEC_W-1:0] vec_d;
   logic [VEC_W-1:0] vec_q;
   logic [LVL_W-1:0] lvl_d;
   logic [LVL_W-1:0] lvl_q;
   logic [ADDR_WIDTH-1:0] addr_d;
   logic [ADDR_WIDTH-1:0] addr_q;
   logic [NUM_VEC-1:0] req_all;
   logic [NUM_VEC-1:0] clr;
   logic [NUM_VEC-1:0] live;
   logic [NUM_VEC-1:0] elig;
   logic [VEC_W:0] result;

   always_comb begin
      // External pins only reach their own slots after synchronising
      req_all = core_req_i;
      req_all[VEC_EXT_A] = core_req_i[VEC_EXT_A] | pin_sync_q[0];
      req_all[VEC_EXT_B] = core_req_i[VEC_EXT_B] | pin_sync_q[1];
      req_all = req_all & assigned;
      // Acknowledge drops only the vector being presented
      clr = '0;
      if (ack_i && irq_q) begin
         clr[vec_q] = 1'b1;
      end
      // A new request in the ack cycle survives: set beats clear
      pend_d = (pend_q & ~clr) | req_all;
      // Arbitrate on what is left after the ack so the next winner is one cycle away
      live = pend_q & ~clr;
      // Masked levels stay pending but are hidden from the core
      for (int v = 0; v < NUM_VEC; v++) begin
         elig[v] = live[v] && assigned[v] &&
                   (levels[v*LVL_W +: LVL_W] >= core_mask_level_i);
      end
      result = pick(elig, levels);
      irq_d = result[VEC_W];
      vec_d = result[VEC_W-1:0];
      lvl_d = levels[vec_d*LVL_W +: LVL_W];
      addr_d = base_q + (ADDR_WIDTH'(vec_d) << VEC_SHIFT);
      // Base changes only on its write strobe
      base_d = vector_table_base_wr_i ? vector_table_base_i : base_q;
   end

   // Registering the winner costs a cycle but keeps outputs glitch free
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pend_q <= '0;
         base_q <= '0;
         irq_q <= 1'b0;
         vec_q <= '0;
         lvl_q <= '0;
         addr_q <= '0;
      end else begin
         pend_q <= pend_d;
         base_q <= base_d;
         irq_q <= irq_d;
         vec_q <= vec_d;
         lvl_q <= lvl_d;
         addr_q <= addr_d;
      end
   end

   // ****************************************
   // Reset overlay addresses
   // ****************************************
   logic [ADDR_WIDTH-1:0] rst_addr_d;
   logic [ADDR_WIDTH-1:0] rst_addr_q;
   logic [ADDR_WIDTH-1:0] wd_addr_d;
   logic [ADDR_WIDTH-1:0] wd_addr_q;
   // Slots 0 and 1 of the table, when the reset addresses overlay it
   always_comb begin
      rst_addr_d = base_q + (ADDR_WIDTH'(VEC_RESET) << VEC_SHIFT);
      wd_addr_d = base_q + (ADDR_WIDTH'(VEC_WATCHDOG_RESET) << VEC_SHIFT);
   end
   // Overlay addresses follow the base one cycle late
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rst_addr_q <= '0;
         wd_addr_q <= '0;
      end else begin
         rst_addr_q <= rst_addr_d;
         wd_addr_q <= wd_addr_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Every output comes straight from a flop
   assign irq_o = irq_q;
   assign vector_num_o = vec_q;
   assign level_o = lvl_q;
   assign vector_addr_o = addr_q;
   assign reset_addr_o = rst_addr_q;
   assign watchdog_reset_addr_o = wd_addr_q;
   assign pending_o = pend_q;
endmodule

//--- testbench/vpiu_core_properties.sv
// Port checker for the interrupt unit
`timescale 1ns/1ps
module vpiu_core_properties
   import vpiu_pkg::*;
#(
   parameter int ADDR_WIDTH = ADDR_W
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [NUM_VEC-1:0] core_req_i,
   input wire logic [LVL_W-1:0] core_mask_level_i,
   input wire logic ack_i,
   input wire logic irq_o,
   input wire logic [VEC_W-1:0] vector_num_o,
   input wire logic [LVL_W-1:0] level_o,
   input wire logic [ADDR_WIDTH-1:0] vector_addr_o,
   input wire logic [ADDR_WIDTH-1:0] reset_addr_o,
   input wire logic [ADDR_WIDTH-1:0] watchdog_reset_addr_o,
   input wire logic [NUM_VEC-1:0] pending_o
);
   // Vectors that may pend; reserved and unassigned ones never do
   localparam logic [NUM_VEC-1:0] USED = 22'h37cefc;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Registered outputs lag reset by one edge, hence the past-reset guards
   a_addr_offset:
      assert property (irq_o |-> vector_addr_o == reset_addr_o + ADDR_WIDTH'({vector_num_o, 1'b0}))
      else $error("vector address off table base");
   a_overlay_addr:
      assert property (!$past(sys_rst_i) |-> watchdog_reset_addr_o == reset_addr_o + ADDR_WIDTH'(2))
      else $error("overlay address wrong");
   a_no_stray:
      assert property ((pending_o & ~USED) == '0 && (!irq_o || USED[vector_num_o]))
      else $error("unassigned vector pends or wins");
   a_mask_level:
      assert property (irq_o && $stable(core_mask_level_i) |-> level_o >= core_mask_level_i)
      else $error("masked level forwarded");
   a_winner_pend:
      assert property (irq_o |-> ($past(pending_o) & (NUM_VEC'(1) << vector_num_o)) != '0)
      else $error("winner was not pending");
   a_pend_hold:
      assert property (!$past(sys_rst_i) |-> ($past(pending_o) & ~pending_o
         & ~($past(ack_i && irq_o) ? NUM_VEC'(1) << $past(vector_num_o) : NUM_VEC'(0))) == '0)
      else $error("pending dropped without ack");
   a_req_pends:
      assert property ((core_req_i & USED) != '0 |=> ($past(core_req_i) & USED & ~pending_o) == '0)
      else $error("request not pending");
   a_fixed_top:
      assert property (irq_o && vector_num_o inside {[5'h02:5'h05]} |-> level_o == LVL_TOP)
      else $error("exception level wrong");
   a_debug_range:
      assert property (irq_o && vector_num_o inside {6, 7, 9, 10, 11} |-> level_o >= DEBUG_LVL_MIN)
      else $error("debug level out of range");
   a_ext_range:
      assert property (irq_o && vector_num_o inside {17, 18, 20, 21} |-> level_o <= EXT_LVL_MAX)
      else $error("external level out of range");
endmodule

//--- testbench/vpiu_core_model.sv
// Behavioural processor core that takes vectors and acknowledges them
`timescale 1ns/1ps
module vpiu_core_model
   import vpiu_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic en_i,
   input wire logic [3:0] delay_i,
   input wire logic irq_i,
   input wire logic [VEC_W-1:0] vector_num_i,
   output logic ack_o
);
   logic [3:0] wait_q;
   logic [VEC_W-1:0] taken_q[$];
   // One ack per presentation after a stall; logs the vector it took
   always @(posedge clk_i) begin
      if (ack_o) taken_q.push_back(vector_num_i);
      if (sys_rst_i || ack_o || !en_i || !irq_i) begin
         ack_o <= 1'b0;
         wait_q <= 4'h0;
      end else if (wait_q >= delay_i) begin
         ack_o <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

//--- testbench/vectored_priority_interrupt_unit_test.sv
// Self-checking bench for the interrupt unit with a core model
`timescale 1ns/1ps
module vectored_priority_interrupt_unit_test import vpiu_pkg::*;;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [NUM_VEC-1:0] core_req_i = '0;
   logic ext_a = 1'b0;
   logic ext_b = 1'b0;
   logic [ADDR_W-1:0] base = '0;
   logic base_wr = 1'b0;
   logic cfg_wr = 1'b0;
   logic [VEC_W-1:0] cfg_vec = '0;
   logic [LVL_W-1:0] cfg_level = '0;
   logic [LVL_W-1:0] mask = '0;
   logic en = 1'b0;
   logic [3:0] delay = '0;
   logic ack, irq;
   logic [VEC_W-1:0] vnum;
   logic [LVL_W-1:0] lvl;
   logic [ADDR_W-1:0] vaddr, raddr, waddr;
   logic [NUM_VEC-1:0] pend;
   logic [VEC_W-1:0] expq[$];
   int bad_count = 0;
   int comparisons = 0;
   vpiu_core vpiu_core_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .core_req_i(core_req_i),
      .external_request_a_i(ext_a), .external_request_b_i(ext_b),
      .vector_table_base_i(base), .vector_table_base_wr_i(base_wr), .cfg_wr_i(cfg_wr),
      .cfg_vec_i(cfg_vec), .cfg_level_i(cfg_level), .core_mask_level_i(mask), .ack_i(ack),
      .irq_o(irq), .vector_num_o(vnum), .level_o(lvl), .vector_addr_o(vaddr),
      .reset_addr_o(raddr), .watchdog_reset_addr_o(waddr), .pending_o(pend));
   vpiu_core_model vpiu_core_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(en),
      .delay_i(delay), .irq_i(irq), .vector_num_i(vnum), .ack_o(ack));
   // Clock at 200 MHz
   initial forever #2.5 clk_i = ~clk_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One-cycle request pulse and level write strobe
   task automatic raise(input logic [NUM_VEC-1:0] bits);
      @(negedge clk_i) core_req_i = bits;
      @(negedge clk_i) core_req_i = '0;
   endtask
   task automatic set_level(input logic [VEC_W-1:0] v, input logic [LVL_W-1:0] l);
      @(negedge clk_i) {cfg_wr, cfg_vec, cfg_level} = {1'b1, v, l};
      @(negedge clk_i) cfg_wr = 1'b0;
   endtask
   // Let the core take every vector shown, then compare the service order
   task automatic serve(input logic [3:0] d);
      int n = 0;
      @(negedge clk_i) {delay, en} = {d, 1'b1};
      while (irq !== 1'b0 && n < 500) begin
         @(negedge clk_i);
         n++;
      end
      en = 1'b0;
      check(irq, 1'b0);
      check(vpiu_core_model_inst.taken_q.size(), expq.size());
      foreach (expq[i]) check(vpiu_core_model_inst.taken_q[i], expq[i]);
      vpiu_core_model_inst.taken_q.delete();
   endtask
   task automatic t_order();
      @(negedge clk_i) {base, base_wr} = {21'h01a000, 1'b1};
      @(negedge clk_i) base_wr = 1'b0;
      raise(22'h03c07c);
      repeat (10) @(negedge clk_i);
      check({irq, vnum, lvl}, {1'b1, 5'h02, LVL_TOP});
      check(vaddr, 21'h01a004);
      check(raddr, 21'h01a000);
      check(waddr, 21'h01a002);
      expq = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h0e, 5'h06, 5'h0f, 5'h10, 5'h11};
      serve(4'h0);
   endtask
   // Clamped and ignored level writes show up as a changed service order
   task automatic t_config();
      set_level(5'h09, 2'h2);
      set_level(5'h0a, 2'h0);
      set_level(5'h15, 2'h3);
      set_level(5'h14, 2'h1);
      set_level(5'h11, 2'h2);
      set_level(5'h03, 2'h0);
      @(negedge clk_i) ext_a = 1'b1;
      raise(22'h300608);
      repeat (3) @(negedge clk_i);
      ext_a = 1'b0;
      repeat (4) @(negedge clk_i);
      expq = '{5'h03, 5'h09, 5'h11, 5'h15, 5'h0a, 5'h14};
      serve(4'h3);
   endtask
   task automatic t_mask();
      @(negedge clk_i) {mask, ext_b} = {2'h2, 1'b1};
      raise(22'h097103);
      repeat (3) @(negedge clk_i);
      ext_b = 1'b0;
      repeat (4) @(negedge clk_i);
      check({irq, vnum}, {1'b1, 5'h0e});
      check(pend, 22'h054000);
      expq = '{5'h0e};
      serve(4'h1);
      check({irq, pend}, {1'b0, 22'h050000});
      @(negedge clk_i) mask = 2'h0;
      repeat (3) @(negedge clk_i);
      expq = '{5'h10, 5'h12};
      serve(4'h1);
   endtask
   // Mid-run reset empties pending work and restores reset levels
   task automatic t_reset();
      set_level(5'h15, 2'h2);
      raise(22'h200040);
      @(negedge clk_i) sys_rst_i = 1'b1;
      @(negedge clk_i) sys_rst_i = 1'b0;
      check({irq, pend}, 23'h000000);
      check(raddr, 21'h000000);
      raise(22'h200040);
      repeat (3) @(negedge clk_i);
      expq = '{5'h06, 5'h15};
      serve(4'h0);
   endtask
   // Main sequence: reset for five cycles, then the scenarios
   initial begin
      repeat (5) @(negedge clk_i);
      sys_rst_i = 1'b0;
      t_order();
      t_config();
      t_mask();
      t_reset();
      give_verdict();
   end
   // Cuts a hang short; the scenarios need well under a thousand cycles
   initial begin
      #50000;
      bad_count++;
      give_verdict();
   end
endmodule
bind vpiu_core vpiu_core_properties #(.ADDR_WIDTH(ADDR_WIDTH)) vpiu_core_properties_inst (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .core_req_i(core_req_i),
   .core_mask_level_i(core_mask_level_i), .ack_i(ack_i), .irq_o(irq_o),
   .vector_num_o(vector_num_o), .level_o(level_o), .vector_addr_o(vector_addr_o),
   .reset_addr_o(reset_addr_o), .watchdog_reset_addr_o(watchdog_reset_addr_o),
   .pending_o(pending_o));
